// ### verilog/port_ingress_class_tag_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module port_ingress_class_tag_ctrl (
  input  wire logic                                       clock_in,
  input  wire logic                                       reset_in,
  input  wire logic                                       ce_in,
  input  wire logic [port_ctrl_pkg::ADDR_W-1:0]           reg_addr_in,
  input  wire logic [port_ctrl_pkg::DATA_W-1:0]           reg_wdata_in,
  input  wire logic                                       reg_wr_in,
  input  wire logic                                       reg_rd_in,
  output logic      [port_ctrl_pkg::DATA_W-1:0]           reg_rdata_out,
  input  wire logic [port_ctrl_pkg::PORTS-1:0]            split_companion_in,
  output logic      [port_ctrl_pkg::PORTS-1:0]            storm_en_out,
  output logic      [port_ctrl_pkg::PORTS-1:0][1:0]       queue_split_out,
  input  wire logic                                       pkt_start_in,
  input  wire logic [port_ctrl_pkg::PSEL_W-1:0]           pkt_ingress_port_in,
  input  wire logic [port_ctrl_pkg::PSEL_W-1:0]           pkt_egress_port_in,
  input  wire logic                                       pkt_tagged_in,
  input  wire logic                                       dscp_valid_in,
  input  wire logic [port_ctrl_pkg::PRIO_W-1:0]           dscp_prio_in,
  input  wire logic                                       dot1p_valid_in,
  input  wire logic [port_ctrl_pkg::PRIO_W-1:0]           dot1p_prio_in,
  input  wire logic [port_ctrl_pkg::VID_W-1:0]            ingress_pvid_in,
  output logic                                            dec_valid_out,
  output logic      [port_ctrl_pkg::PRIO_W-1:0]           dec_queue_out,
  output logic                                            dec_storm_out,
  output logic                                            dec_insert_out,
  output logic                                            dec_remove_out,
  output logic      [port_ctrl_pkg::VID_W-1:0]            dec_vid_out
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [port_ctrl_pkg::PORTS-1:0][port_ctrl_pkg::DATA_W-1:0] ctrl;
    logic [port_ctrl_pkg::DATA_W-1:0]                           rdata;
    logic                                                       dec_valid;
    logic [port_ctrl_pkg::PRIO_W-1:0]                           dec_queue;
    logic                                                       dec_storm;
    logic                                                       dec_ins;
    logic                                                       dec_rem;
    logic [port_ctrl_pkg::VID_W-1:0]                            dec_vid;
    logic [port_ctrl_pkg::PORTS-1:0]                            split_comp;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  // ----------------------------------------
  // Address decode
  // ----------------------------------------
  logic                              hit;
  logic [port_ctrl_pkg::PSEL_W-1:0]  hit_idx;

  always_comb begin
    hit     = 1'b0;
    hit_idx = '0;
    for (int i = 0; i < port_ctrl_pkg::PORTS; i++) begin
      if (reg_addr_in == port_ctrl_pkg::PORT_CTRL_OFF[i]) begin
        hit     = 1'b1;
        hit_idx = port_ctrl_pkg::PSEL_W'(i);
      end
    end
  end

  // ----------------------------------------
  // Packet decision
  // ----------------------------------------
  logic [port_ctrl_pkg::DATA_W-1:0] ing_ctrl;
  logic [port_ctrl_pkg::DATA_W-1:0] eg_ctrl;
  logic                             use_dscp;
  logic                             use_dot1p;
  logic [port_ctrl_pkg::PRIO_W-1:0] class_prio;

  assign ing_ctrl  = state_r.ctrl[pkt_ingress_port_in];
  assign eg_ctrl   = state_r.ctrl[pkt_egress_port_in];
  assign use_dscp  = ing_ctrl[port_ctrl_pkg::DSCP_BIT] & dscp_valid_in;
  assign use_dot1p = ing_ctrl[port_ctrl_pkg::DOT1P_BIT] & dot1p_valid_in;

  always_comb begin
    class_prio = '0;
    if (use_dscp) begin
      class_prio = class_prio | dscp_prio_in;
    end
    if (use_dot1p) begin
      class_prio = class_prio | dot1p_prio_in;
    end
    if (!use_dscp && !use_dot1p) begin
      class_prio = ing_ctrl[port_ctrl_pkg::PRIO_HI:port_ctrl_pkg::PRIO_LO];
    end
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_nxt           = state_r;
    state_nxt.dec_valid = 1'b0;
    state_nxt.split_comp = split_companion_in;
    if (reg_wr_in && hit) begin
      state_nxt.ctrl[hit_idx] = reg_wdata_in;
    end
    if (reg_rd_in) begin
      state_nxt.rdata = hit ? state_r.ctrl[hit_idx] : port_ctrl_pkg::READ_ZERO;
    end
    // Decision uses register values as they stood before any same-cycle write
    if (pkt_start_in) begin
      state_nxt.dec_valid = 1'b1;
      state_nxt.dec_queue = class_prio;
      state_nxt.dec_storm = ing_ctrl[port_ctrl_pkg::STORM_BIT];
      state_nxt.dec_ins   = eg_ctrl[port_ctrl_pkg::INSERT_BIT] & ~pkt_tagged_in;
      state_nxt.dec_rem   = eg_ctrl[port_ctrl_pkg::REMOVE_BIT] & pkt_tagged_in;
      state_nxt.dec_vid   = ingress_pvid_in;
    end
  end

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      state_r <= '0;
      for (int i = 0; i < port_ctrl_pkg::PORTS; i++) begin
        state_r.ctrl[i] <= port_ctrl_pkg::CTRL_RESET;
      end
    end else if (ce_in) begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  for (genvar g = 0; g < port_ctrl_pkg::PORTS; g++) begin : g_port
    assign storm_en_out[g]    = state_r.ctrl[g][port_ctrl_pkg::STORM_BIT];
    assign queue_split_out[g] = {state_r.split_comp[g], state_r.ctrl[g][port_ctrl_pkg::SPLIT_BIT]};
  end

  assign reg_rdata_out  = state_r.rdata;
  assign dec_valid_out  = state_r.dec_valid;
  assign dec_queue_out  = state_r.dec_queue;
  assign dec_storm_out  = state_r.dec_storm;
  assign dec_insert_out = state_r.dec_ins;
  assign dec_remove_out = state_r.dec_rem;
  assign dec_vid_out    = state_r.dec_vid;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (reset_in);

  sequence s_write_port;
    ce_in && reg_wr_in && hit;
  endsequence

  sequence s_read_same;
    ce_in && reg_rd_in && !reg_wr_in && hit && (reg_addr_in == $past(reg_addr_in));
  endsequence

  sequence s_decide;
    ce_in && pkt_start_in;
  endsequence

  sequence s_no_decide;
    ce_in && !pkt_start_in;
  endsequence

  a_write_then_read: assert property (s_write_port ##1 s_read_same |=> reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("Read after write does not return written value");

  a_reserved_reads_zero: assert property (ce_in && reg_rd_in && reg_addr_in == port_ctrl_pkg::RSVD_OFF |=> reg_rdata_out == port_ctrl_pkg::READ_ZERO)
    else $error("Reserved offset does not read zero");

  a_storm_follows: assert property (s_write_port |=> storm_en_out[$past(hit_idx)] == $past(reg_wdata_in[port_ctrl_pkg::STORM_BIT]))
    else $error("Storm enable not taken from write");

  a_default_prio: assert property (ce_in && pkt_start_in && !use_dscp && !use_dot1p |=>
                                   dec_valid_out && dec_queue_out == $past(ing_ctrl[port_ctrl_pkg::PRIO_HI:port_ctrl_pkg::PRIO_LO]))
    else $error("Port default queue not used");

  a_or_prio: assert property (ce_in && pkt_start_in && use_dscp && use_dot1p |=>
                              dec_queue_out == ($past(dscp_prio_in) | $past(dot1p_prio_in)))
    else $error("Classifier priorities not combined by OR");

  a_dscp_only: assert property (ce_in && pkt_start_in && use_dscp && !use_dot1p |=> dec_queue_out == $past(dscp_prio_in))
    else $error("DSCP priority not applied");

  a_dot1p_off: assert property (ce_in && pkt_start_in && !ing_ctrl[port_ctrl_pkg::DOT1P_BIT] && !use_dscp |=>
                                dec_queue_out == $past(ing_ctrl[port_ctrl_pkg::PRIO_HI:port_ctrl_pkg::PRIO_LO]))
    else $error("Disabled 802.1p still classifies");

  a_insert_untagged: assert property (ce_in && pkt_start_in |=>
                                      dec_insert_out == ($past(eg_ctrl[port_ctrl_pkg::INSERT_BIT]) && !$past(pkt_tagged_in)))
    else $error("Tag insertion decision wrong");

  a_no_double_tag: assert property (ce_in && pkt_start_in && pkt_tagged_in |=> !dec_insert_out)
    else $error("Second tag inserted");

  a_insert_vid: assert property (ce_in && pkt_start_in && !pkt_tagged_in |=> dec_vid_out == $past(ingress_pvid_in))
    else $error("Inserted VID not ingress default");

  a_remove_tagged: assert property (ce_in && pkt_start_in && pkt_tagged_in |=>
                                    dec_remove_out == $past(eg_ctrl[port_ctrl_pkg::REMOVE_BIT]))
    else $error("Tag removal decision wrong");

  a_untagged_unmodified: assert property (ce_in && pkt_start_in && !pkt_tagged_in |=> !dec_remove_out)
    else $error("Untagged packet modified by removal");

  a_old_value_used: assert property (ce_in && pkt_start_in && reg_wr_in && hit && hit_idx == pkt_ingress_port_in |=>
                                     dec_storm_out == $past(ing_ctrl[port_ctrl_pkg::STORM_BIT]))
    else $error("In-flight packet saw new setting");

  a_split_sel: assert property (s_write_port ##1 ce_in |->
                                queue_split_out[$past(hit_idx)][0] == $past(reg_wdata_in[port_ctrl_pkg::SPLIT_BIT]))
    else $error("Queue split bit not from register");

  // ----------------------------------------
  // Address decode checks
  // ----------------------------------------
  a_hit_map: assert property (hit |-> port_ctrl_pkg::PORT_CTRL_OFF[hit_idx] == reg_addr_in)
    else $error("Decoded port does not match offset");

  a_reserved_no_hit: assert property (reg_addr_in == port_ctrl_pkg::RSVD_OFF |-> !hit)
    else $error("Reserved offset decoded as a port");

  // ----------------------------------------
  // Register bus checks
  // ----------------------------------------
  a_write_lands: assert property (s_write_port |=> state_r.ctrl[$past(hit_idx)] == $past(reg_wdata_in))
    else $error("Write did not land in port register");

  a_miss_ignored: assert property (ce_in && reg_wr_in && !hit |=> $stable(state_r.ctrl))
    else $error("Write to unmapped offset changed a register");

  a_read_hit: assert property (ce_in && reg_rd_in && hit |=>
    reg_rdata_out == $past(state_r.ctrl[hit_idx]))
    else $error("Read of port register returned wrong value");

  a_read_miss: assert property (ce_in && reg_rd_in && !hit |=> reg_rdata_out == port_ctrl_pkg::READ_ZERO)
    else $error("Read of unmapped offset not zero");

  a_rdata_holds: assert property (ce_in && !reg_rd_in |=> $stable(reg_rdata_out))
    else $error("Read data changed without a read");

  // ----------------------------------------
  // Decision checks
  // ----------------------------------------
  a_dec_pulse: assert property (s_decide |=> dec_valid_out)
    else $error("Decision not reported");

  a_dec_hold: assert property (s_no_decide |=>
    !dec_valid_out && $stable(dec_queue_out) && $stable(dec_storm_out) && $stable(dec_insert_out) &&
    $stable(dec_remove_out) && $stable(dec_vid_out))
    else $error("Decision outputs changed without a request");

  a_storm_decision: assert property (s_decide |=> dec_storm_out == $past(ing_ctrl[port_ctrl_pkg::STORM_BIT]))
    else $error("Storm flag not from ingress port");

  a_dscp_off: assert property (s_decide ##0 (!ing_ctrl[port_ctrl_pkg::DSCP_BIT] && !use_dot1p) |=>
    dec_queue_out == $past(ing_ctrl[port_ctrl_pkg::PRIO_HI:port_ctrl_pkg::PRIO_LO]))
    else $error("Port default queue not used with DiffServ off");

  a_dot1p_only: assert property (s_decide ##0 (use_dot1p && !use_dscp) |=> dec_queue_out == $past(dot1p_prio_in))
    else $error("802.1p priority not applied");

  a_dscp_fail: assert property (s_decide ##0 (!dscp_valid_in && !use_dot1p) |=>
    dec_queue_out == $past(ing_ctrl[port_ctrl_pkg::PRIO_HI:port_ctrl_pkg::PRIO_LO]))
    else $error("Port default queue not used after DiffServ miss");

  a_dot1p_fail: assert property (s_decide ##0 (!dot1p_valid_in && !use_dscp) |=>
    dec_queue_out == $past(ing_ctrl[port_ctrl_pkg::PRIO_HI:port_ctrl_pkg::PRIO_LO]))
    else $error("Port default queue not used after 802.1p miss");

  a_insert_on: assert property (s_decide ##0 (eg_ctrl[port_ctrl_pkg::INSERT_BIT] && !pkt_tagged_in) |=> dec_insert_out)
    else $error("Untagged packet not tagged");

  a_insert_off: assert property (s_decide ##0 (!eg_ctrl[port_ctrl_pkg::INSERT_BIT]) |=> !dec_insert_out)
    else $error("Tag inserted with insertion off");

  a_one_tag_action: assert property (s_decide |=> !(dec_insert_out && dec_remove_out))
    else $error("Tag both inserted and removed");

  a_vid_captured: assert property (s_decide |=> dec_vid_out == $past(ingress_pvid_in))
    else $error("Decision VID not ingress default");

  a_remove_on: assert property (s_decide ##0 (eg_ctrl[port_ctrl_pkg::REMOVE_BIT] && pkt_tagged_in) |=> dec_remove_out)
    else $error("Tagged packet not stripped");

  a_remove_off: assert property (s_decide ##0 (!eg_ctrl[port_ctrl_pkg::REMOVE_BIT]) |=> !dec_remove_out)
    else $error("Tag removed with removal off");

  // ----------------------------------------
  // Clock enable, reset and split checks
  // ----------------------------------------
  a_ce_freeze: assert property (!ce_in |=> $stable(state_r))
    else $error("State moved while clock enable low");

  a_reset_clears: assert property (disable iff (1'b0) reset_in |=>
    state_r.ctrl == {port_ctrl_pkg::PORTS{port_ctrl_pkg::CTRL_RESET}} &&
    reg_rdata_out == port_ctrl_pkg::READ_ZERO && !dec_valid_out)
    else $error("Reset did not clear registers");

  for (genvar g = 0; g < port_ctrl_pkg::PORTS; g++) begin : g_split_chk
    a_split_companion: assert property (ce_in |=> queue_split_out[g][1] == $past(split_companion_in[g]))
      else $error("Companion split bit not registered");
  end

endmodule
`default_nettype wire

// ### shared/port_ctrl_pkg.sv
// Operation
// - Bit 7 of a port control register turns broadcast storm protection on for packets entering that port.
// - Bit 6 turns DiffServ code point priority classification on for packets entering that port.
// - Bit 5 turns 802.1p priority field classification on for packets entering that port.
// - Bits 4 to 3 give the default queue 0 to 3 used when no enabled classifier yields a priority.
// - All classifiers may be on at once, and then the OR of the 802.1p and DSCP priorities replaces the port default.
// - Bit 2 makes the port add an 802.1q tag to every packet it sends that arrived untagged.
// - With insertion on, a packet that arrived tagged goes out unchanged and never gets a second tag.
// - An inserted tag carries the default VID of the ingress port, not of the egress port.
// - Bit 1 makes the port strip the 802.1q tag from every tagged packet it sends.
// - With removal on, a packet that arrived untagged goes out with its header unmodified.
// - Ports 1 to 4 each have one identical control register at 0x20, 0x30, 0x40 and 0x50, and 0x10 is reserved.
// - Bit 0 together with a companion bit held elsewhere selects one, two or four output queues for the port.
`default_nettype none
package port_ctrl_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PORTS  = 4;
  localparam int unsigned PRIO_W = 2;
  localparam int unsigned VID_W  = 12;
  localparam int unsigned PSEL_W = 2;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] RSVD_OFF = 8'h10;
  localparam logic [PORTS-1:0][ADDR_W-1:0] PORT_CTRL_OFF = {8'h50, 8'h40, 8'h30, 8'h20};
  localparam logic [DATA_W-1:0] CTRL_RESET  = 8'h00;
  localparam logic [DATA_W-1:0] READ_ZERO   = 8'h00;

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int unsigned STORM_BIT  = 7;
  localparam int unsigned DSCP_BIT   = 6;
  localparam int unsigned DOT1P_BIT  = 5;
  localparam int unsigned PRIO_HI    = 4;
  localparam int unsigned PRIO_LO    = 3;
  localparam int unsigned INSERT_BIT = 2;
  localparam int unsigned REMOVE_BIT = 1;
  localparam int unsigned SPLIT_BIT  = 0;

endpackage
`default_nettype wire

// ### test/test_port_ingress_class_tag_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module test_port_ingress_class_tag_ctrl;
  logic            clock_in, reset_in, ce_in, reg_wr_in, reg_rd_in, pkt_start_in, pkt_tagged_in;
  logic [7:0]      reg_addr_in, reg_wdata_in, reg_rdata_out;
  logic [3:0]      split_companion_in, storm_en_out;
  logic [3:0][1:0] queue_split_out;
  logic [1:0]      pkt_ingress_port_in, pkt_egress_port_in, dscp_prio_in, dot1p_prio_in, dec_queue_out;
  logic            dscp_valid_in, dot1p_valid_in, dec_valid_out, dec_storm_out, dec_insert_out, dec_remove_out;
  logic [11:0]     ingress_pvid_in, dec_vid_out;
  logic [7:0]      ctrl [4];
  int              n_errors, n_compared;

  port_ingress_class_tag_ctrl u_dut (.clock_in(clock_in), .reset_in(reset_in), .ce_in(ce_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .split_companion_in(split_companion_in), .storm_en_out(storm_en_out),
    .queue_split_out(queue_split_out), .pkt_start_in(pkt_start_in), .pkt_ingress_port_in(pkt_ingress_port_in),
    .pkt_egress_port_in(pkt_egress_port_in), .pkt_tagged_in(pkt_tagged_in), .dscp_valid_in(dscp_valid_in),
    .dscp_prio_in(dscp_prio_in), .dot1p_valid_in(dot1p_valid_in), .dot1p_prio_in(dot1p_prio_in),
    .ingress_pvid_in(ingress_pvid_in), .dec_valid_out(dec_valid_out), .dec_queue_out(dec_queue_out),
    .dec_storm_out(dec_storm_out), .dec_insert_out(dec_insert_out), .dec_remove_out(dec_remove_out),
    .dec_vid_out(dec_vid_out));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_in);
    reg_addr_in = a;
    reg_wdata_in = d;
    reg_wr_in = 1'h1;
    @(negedge clock_in);
    reg_wr_in = 1'h0;
    if (a[3:0] == 4'h0 && a[7:4] >= 4'h2 && a[7:4] <= 4'h5) begin
      ctrl[2'(a[7:4] - 4'h2)] = d;
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock_in);
    reg_addr_in = a;
    reg_rd_in = 1'h1;
    @(negedge clock_in);
    reg_rd_in = 1'h0;
    check("reg_rdata_out", {9'h000, reg_rdata_out}, {9'h000, exp});
  endtask

  // Write immediately followed by a read of the same port register
  task automatic wr_rd(input logic [1:0] p, input logic [7:0] d);
    @(negedge clock_in);
    reg_addr_in = port_ctrl_pkg::PORT_CTRL_OFF[p];
    reg_wdata_in = d;
    reg_wr_in = 1'h1;
    @(negedge clock_in);
    reg_wr_in = 1'h0;
    reg_rd_in = 1'h1;
    ctrl[p] = d;
    @(negedge clock_in);
    reg_rd_in = 1'h0;
    check("reg_rdata_out", {9'h000, reg_rdata_out}, {9'h000, d});
  endtask

  // Packet decision, optionally with a write to the ingress port in the same cycle
  task automatic decide(input logic [4:0] i, input logic w);
    logic       dv, pv;
    logic [1:0] ing, egr, q;
    ing = i[1:0];
    egr = i[3:2];
    @(negedge clock_in);
    pkt_start_in = 1'h1;
    pkt_ingress_port_in = ing;
    pkt_egress_port_in = egr;
    pkt_tagged_in = i[4];
    dscp_valid_in = i[0] ^ i[3];
    dscp_prio_in = i[2:1];
    dot1p_valid_in = i[1] ^ i[4];
    dot1p_prio_in = i[3:2];
    ingress_pvid_in = {i, 7'h5a};
    reg_wr_in = w;
    reg_addr_in = port_ctrl_pkg::PORT_CTRL_OFF[ing];
    reg_wdata_in = ~ctrl[ing];
    dv = dscp_valid_in & ctrl[ing][6];
    pv = dot1p_valid_in & ctrl[ing][5];
    q = (dv | pv) ? ((dv ? dscp_prio_in : 2'h0) | (pv ? dot1p_prio_in : 2'h0)) : ctrl[ing][4:3];
    @(negedge clock_in);
    pkt_start_in = 1'h0;
    reg_wr_in = 1'h0;
    check("dec_valid_out", {16'h0000, dec_valid_out}, 17'h0_0001);
    check("dec_fields", {dec_queue_out, dec_storm_out, dec_insert_out, dec_remove_out, dec_vid_out},
          {q, ctrl[ing][7], ctrl[egr][2] & ~i[4], ctrl[egr][1] & i[4], ingress_pvid_in});
    if (w) begin
      ctrl[ing] = ~ctrl[ing];
    end
    @(negedge clock_in);
    check("dec_valid_out", {16'h0000, dec_valid_out}, 17'h0_0000);
  endtask

  task automatic results;
    $display("Compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Clock, watchdog and tests
  // ----------------------------------------
  initial begin
    clock_in = 1'h0;
    forever #10 clock_in = ~clock_in;
  end

  initial begin
    repeat (3000) @(posedge clock_in);
    n_errors++;
    $display("ERROR watchdog expected end of tests seen timeout");
    results();
  end

  initial begin
    {reset_in, ce_in, reg_wr_in, reg_rd_in, pkt_start_in, pkt_tagged_in} = 6'h31;
    {reg_addr_in, reg_wdata_in, pkt_ingress_port_in, pkt_egress_port_in} = 20'h0_0000;
    {dscp_valid_in, dot1p_valid_in, dscp_prio_in, dot1p_prio_in, ingress_pvid_in} = 18'h0_0000;
    split_companion_in = 4'h5;
    for (int p = 0; p < 4; p++) ctrl[p] = 8'h00;
    n_errors = 0;
    n_compared = 0;
    repeat (2) @(negedge clock_in);
    reset_in = 1'h0;
    for (int p = 0; p < 4; p++) rd(port_ctrl_pkg::PORT_CTRL_OFF[p], 8'h00);
    rd(8'h10, 8'h00);
    $display("Test reset_values done");
    wr(8'h20, 8'hea);
    wr(8'h30, 8'h54);
    wr(8'h40, 8'h3b);
    wr(8'h50, 8'h87);
    wr(8'h10, 8'hff);
    wr(8'h21, 8'hff);
    for (int p = 0; p < 4; p++) rd(port_ctrl_pkg::PORT_CTRL_OFF[p], ctrl[p]);
    rd(8'h10, 8'h00);
    rd(8'h21, 8'h00);
    check("storm_en_out", {13'h0000, storm_en_out}, {13'h0000, ctrl[3][7], ctrl[2][7], ctrl[1][7], ctrl[0][7]});
    for (int p = 0; p < 4; p++) check("queue_split_out", {15'h0000, queue_split_out[p]}, {15'h0000, split_companion_in[p], ctrl[p][0]});
    $display("Test register_map done");
    for (int i = 0; i < 32; i++) decide(5'(i), 1'h0);
    $display("Test decisions done");
    decide(5'h05, 1'h1);
    decide(5'h05, 1'h0);
    rd(8'h30, ctrl[1]);
    $display("Test write_during_decision done");
    @(negedge clock_in);
    ce_in = 1'h0;
    reg_wr_in = 1'h1;
    reg_addr_in = 8'h40;
    reg_wdata_in = 8'h00;
    pkt_start_in = 1'h1;
    @(negedge clock_in);
    ce_in = 1'h1;
    reg_wr_in = 1'h0;
    pkt_start_in = 1'h0;
    check("dec_valid_out", {16'h0000, dec_valid_out}, 17'h0_0000);
    check("storm_en_out", {13'h0000, storm_en_out}, {13'h0000, ctrl[3][7], ctrl[2][7], ctrl[1][7], ctrl[0][7]});
    rd(8'h40, ctrl[2]);
    $display("Test clock_enable done");
    @(negedge clock_in);
    reset_in = 1'h1;
    ce_in = 1'h0;
    repeat (2) @(negedge clock_in);
    reset_in = 1'h0;
    ce_in = 1'h1;
    for (int p = 0; p < 4; p++) ctrl[p] = 8'h00;
    check("dec_fields", {dec_queue_out, dec_storm_out, dec_insert_out, dec_remove_out, dec_vid_out}, 17'h0_0000);
    check("dec_valid_out", {16'h0000, dec_valid_out}, 17'h0_0000);
    check("reg_rdata_out", {9'h000, reg_rdata_out}, 17'h0_0000);
    check("storm_en_out", {13'h0000, storm_en_out}, 17'h0_0000);
    for (int p = 0; p < 4; p++) check("queue_split_out", {16'h0000, queue_split_out[p][0]}, 17'h0_0000);
    for (int p = 0; p < 4; p++) rd(port_ctrl_pkg::PORT_CTRL_OFF[p], 8'h00);
    wr_rd(2'h2, 8'h3b);
    $display("Test mid_run_reset done");
    results();
  end
endmodule
`default_nettype wire
